// >>> logic/aftp_packer.sv
`timescale 1ns/1ns
`default_nettype none
`include "aftp_map.svh"
module aftp_packer
    import aftp_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Sample input.
    input wire logic smp_valid,
    output logic smp_ready,
    input wire aftp_sample_s smp,
    // Serial message enable for airflow sensors.
    input wire logic ser_enable,
    // Frame output.
    output logic frm_valid,
    input wire logic frm_ready,
    output aftp_frame_s frm
);
    // ==========================================
    // Class code decoding. Codes outside the airflow range fall back to an
    // even split, which also suits the unspecified class.
    function automatic aftp_split_e split_of(input logic [11:0] c);
        if (c >= `AFTP_CLS_16_LO && c <= `AFTP_CLS_16_HI)
            return AFTP_SPLIT_16_8;
        if (c >= `AFTP_CLS_16T_LO && c <= `AFTP_CLS_16T_HI)
            return AFTP_SPLIT_16_8;
        if (c >= `AFTP_CLS_14_LO && c <= `AFTP_CLS_14T_HI)
            return AFTP_SPLIT_14_10;
        return AFTP_SPLIT_12_12;
    endfunction : split_of

    // Classes whose second channel is listed as zeros.
    function automatic logic ch2_unused(input logic [11:0] c);
        return c == `AFTP_CLS_ZERO_A || c == `AFTP_CLS_ZERO_B
            || c == `AFTP_CLS_ZERO_C || c == `AFTP_CLS_ZERO_D
            || c == `AFTP_CLS_ZERO_E;
    endfunction : ch2_unused

    // ==========================================
    // Field coding helpers.
    // Reserved signalling code for a failed airflow field, as wide as the
    // split allows. All ones was chosen so the receiver needs one compare
    // per width; any other value of the reserved range would serve as well.
    function automatic logic [15:0] ch1_err_code(input aftp_split_e s);
        case (s)
            AFTP_SPLIT_16_8: return `AFTP_ERR16;
            AFTP_SPLIT_14_10: return {2'h0, `AFTP_ERR14};
            default: return {4'h0, `AFTP_ERR12};
        endcase
    endfunction : ch1_err_code

    // Same for the second channel, whose width is whatever the split leaves.
    // Upper bits stay zero so the packing step can slice without masking.
    function automatic logic [11:0] ch2_err_code(input aftp_split_e s);
        case (s)
            AFTP_SPLIT_16_8: return {4'h0, `AFTP_ERR8};
            AFTP_SPLIT_14_10: return {2'h0, `AFTP_ERR10};
            default: return `AFTP_ERR12;
        endcase
    endfunction : ch2_err_code

    // Legacy error byte: one bit per out-of-range flag. The two top bits are
    // reserved and stay zero, so an older receiver never misreads them.
    function automatic logic [7:0] err_byte_of(input logic [5:0] r);
        logic [7:0] b;
        b = 8'h00;
        b[`AFTP_EB_TEMP_HI] = r[`AFTP_EB_TEMP_HI];
        b[`AFTP_EB_TEMP_LO] = r[`AFTP_EB_TEMP_LO];
        b[`AFTP_EB_HUM_HI] = r[`AFTP_EB_HUM_HI];
        b[`AFTP_EB_HUM_LO] = r[`AFTP_EB_HUM_LO];
        b[`AFTP_EB_BARO_HI] = r[`AFTP_EB_BARO_HI];
        b[`AFTP_EB_BARO_LO] = r[`AFTP_EB_BARO_LO];
        return b;
    endfunction : err_byte_of

    // Lay the two fields into the six nibbles. Channel 1 always leads, so the
    // airflow value starts in the first nibble whatever the split; only the
    // width of each field changes.
    function automatic logic [23:0] pack_fields(input aftp_split_e s,
        input logic [15:0] a, input logic [11:0] b);
        case (s)
            AFTP_SPLIT_16_8: return {a, b[7:0]};
            AFTP_SPLIT_14_10: return {a[13:0], b[9:0]};
            default: return {a[11:0], b};
        endcase
    endfunction : pack_fields

    // Working values of the frame being assembled; nothing here is stored,
    // the fifo below takes the finished frame in the same cycle.
    aftp_frame_s pk;
    logic [15:0] f1;
    logic [11:0] f2;
    logic any_err;
    aftp_split_e sp;

    // ==========================================
    // Frame assembly, purely combinational from the sample.
    // Fault substitution is done before packing, and on the packed nibbles in
    // dual throttle mode, so the receiver sees whole
    // fields replaced, never a half-valid value.
    always_comb begin
        pk = '0;
        sp = split_of(smp.class_code);
        f1 = smp.ch1;
        f2 = ch2_unused(smp.class_code) ? 12'h000 : smp.ch2;
        any_err = |smp.range_flags;
        pk.class_code = smp.class_code;
        if (smp.dual_throttle) begin
            // Dual throttle: two 12-bit positions, each replaced whole.
            pk.split = AFTP_SPLIT_12_12;
            pk.nibbles = {smp.ch1[11:0], smp.ch2};
            if (smp.ch1_fault)
                pk.nibbles[23:12] = {3{`AFTP_TPS_A_FAULT}};
            if (smp.ch2_fault)
                pk.nibbles[11:0] = {3{`AFTP_TPS_B_FAULT}};
            pk.ser_fmt = AFTP_SER_NONE;
        end else begin
            pk.split = sp;
            // Legacy mode has no reserved codes, so a failed field reads as
            // zero; the receiver must know in advance which mode is in use,
            // because zero is also a legal measurement there.
            if (smp.legacy) begin
                if (smp.ch1_fault)
                    f1 = {4{`AFTP_LEGACY_FAULT}};
                if (smp.ch2_fault)
                    f2 = {3{`AFTP_LEGACY_FAULT}};
            end else begin
                // A reserved code replaces the whole field; an unused second
                // channel stays at zero even when its source is flagged bad.
                if (smp.ch1_fault)
                    f1 = ch1_err_code(sp);
                if (smp.ch2_fault && !ch2_unused(smp.class_code))
                    f2 = ch2_err_code(sp);
            end
            // Airflow on channel 1, second quantity on channel 2.
            pk.nibbles = pack_fields(sp, f1, f2);
            // Serial content only for airflow sensors. The short format is
            // kept for older receivers and speaks up only when a range flag
            // is set; new designs get the enhanced format.
            if (ser_enable) begin
                if (smp.legacy) begin
                    pk.ser_fmt = AFTP_SER_SHORT;
                    pk.ser_err_valid = any_err;
                    pk.ser_err_id = `AFTP_MSG_ERR_ID;
                    pk.ser_err_byte = err_byte_of(smp.range_flags);
                end else begin
                    pk.ser_fmt = AFTP_SER_ENH;
                end
            end
        end
    end

    // ==========================================
    // Packed frames queue here until the nibble transmitter takes them.
    // Handshake between the fifo and the output stage.
    logic q_valid;
    aftp_frame_s q_data;
    logic ov_ff, nxt_ov;
    aftp_frame_s fr_ff, nxt_fr;
    logic q_ready;

    // The finished frame is stored, not the raw sample, so a fault flag that
    // changes later can never rewrite a frame already in the queue.
    aftp_fifo #(
        .WIDTH($bits(aftp_frame_s)),
        .DEPTH(`AFTP_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(smp_valid),
        .in_ready(smp_ready),
        .in_data(pk),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_data)
    );

    // ==========================================
    // Output skid register keeps outputs straight from flops.
    // The transmitter may hold a frame for a whole frame time; this stage
    // lets it do so while the fifo keeps filling behind it.
    always_comb begin
        q_ready = !ov_ff || frm_ready;
        nxt_ov = ov_ff && !frm_ready;
        nxt_fr = fr_ff;
        if (q_ready && q_valid) begin
            nxt_ov = 1'b1;
            nxt_fr = q_data;
        end
    end

    // Register the output stage.
    always_ff @(posedge clk) begin
        if (srst) begin
            ov_ff <= 1'b0;
            fr_ff <= '0;
        end else begin
            ov_ff <= nxt_ov;
            fr_ff <= nxt_fr;
        end
    end

    assign frm_valid = ov_ff;
    assign frm = fr_ff;
endmodule : aftp_packer
`default_nettype wire

// >>> logic/aftp_map.svh
`ifndef AFTP_MAP_SVH
`define AFTP_MAP_SVH
// Nibble forced on every data nibble of a faulty first throttle sensor.
`define AFTP_TPS_A_FAULT 4'hF
// Nibble forced on every data nibble of a faulty second throttle sensor.
`define AFTP_TPS_B_FAULT 4'h0
// Legacy fault value for an airflow or second-channel field.
`define AFTP_LEGACY_FAULT 4'h0
// Reserved signalling codes for new designs, per channel width.
`define AFTP_ERR16 16'hFFFF
`define AFTP_ERR14 14'h3FFF
`define AFTP_ERR12 12'hFFF
`define AFTP_ERR10 10'h3FF
`define AFTP_ERR8 8'hFF
// Sensor-class codes.
`define AFTP_CLS_UNSPEC 12'h010
`define AFTP_CLS_MIN 12'h011
`define AFTP_CLS_16_LO 12'h011
`define AFTP_CLS_16_HI 12'h014
`define AFTP_CLS_14_LO 12'h015
`define AFTP_CLS_14_HI 12'h018
`define AFTP_CLS_14T_LO 12'h019
`define AFTP_CLS_14T_HI 12'h01A
`define AFTP_CLS_16T_LO 12'h01B
`define AFTP_CLS_16T_HI 12'h01C
`define AFTP_CLS_12_LO 12'h01D
`define AFTP_CLS_12_HI 12'h01F
// Classes whose second channel is unused and sends zeros.
`define AFTP_CLS_ZERO_A 12'h011
`define AFTP_CLS_ZERO_B 12'h012
`define AFTP_CLS_ZERO_C 12'h017
`define AFTP_CLS_ZERO_D 12'h018
`define AFTP_CLS_ZERO_E 12'h01D
// Legacy short serial error byte bit positions.
`define AFTP_EB_TEMP_HI 0
`define AFTP_EB_TEMP_LO 1
`define AFTP_EB_HUM_HI 2
`define AFTP_EB_HUM_LO 3
`define AFTP_EB_BARO_HI 4
`define AFTP_EB_BARO_LO 5
`define AFTP_MSG_ERR_ID 4'hF
`define AFTP_FIFO_DEPTH 16
`endif

// >>> logic/aftp_pkg.sv
`default_nettype none
package aftp_pkg;
    typedef enum logic [1:0] {AFTP_SPLIT_16_8, AFTP_SPLIT_14_10,
        AFTP_SPLIT_12_12} aftp_split_e;
    typedef enum logic [1:0] {AFTP_SER_NONE, AFTP_SER_SHORT,
        AFTP_SER_ENH} aftp_ser_e;
    // One measurement sample from the sensing side.
    typedef struct packed {
        logic dual_throttle;
        logic [11:0] class_code;
        logic legacy;
        logic [15:0] ch1;
        logic [11:0] ch2;
        logic ch1_fault;
        logic ch2_fault;
        logic [5:0] range_flags;
    } aftp_sample_s;
    // One packed fast-channel frame.
    typedef struct packed {
        logic [23:0] nibbles;
        aftp_split_e split;
        logic [11:0] class_code;
        aftp_ser_e ser_fmt;
        logic ser_err_valid;
        logic [3:0] ser_err_id;
        logic [7:0] ser_err_byte;
    } aftp_frame_s;
endpackage : aftp_pkg
`default_nettype wire

// >>> logic/aftp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module aftp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic [WIDTH-1:0] dout_ff, nxt_dout;
    logic ov_ff, nxt_ov;
    logic rdy_ff, nxt_rdy;
    logic push, pop;

    // ==========================================
    // Pointers and output register.
    // Read data sit in a register so the drain side sees a clean flop.
    always_comb begin
        pop = out_valid && out_ready;
        nxt_ov = ov_ff && !pop;
        nxt_dout = dout_ff;
        nxt_rp = rp_ff;
        if ((!ov_ff || pop) && cnt_ff != '0) begin
            nxt_ov = 1'b1;
            nxt_dout = mem_ff[rp_ff];
            nxt_rp = rp_ff + 1'b1;
        end
        push = in_valid && in_ready;
        nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
        nxt_cnt = cnt_ff + {{AW{1'b0}}, push}
            - {{AW{1'b0}}, (nxt_rp != rp_ff)};
        // Ready is worked out a cycle ahead so that it leaves a flop.
        nxt_rdy = (nxt_cnt != DEPTH[AW:0]);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            ov_ff <= 1'b0;
            dout_ff <= '0;
            rdy_ff <= 1'b1;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            ov_ff <= nxt_ov;
            dout_ff <= nxt_dout;
            rdy_ff <= nxt_rdy;
        end
        if (push) begin
            mem_ff[wp_ff] <= in_data;
        end
    end

    assign in_ready = rdy_ff;
    assign out_valid = ov_ff;
    assign out_data = dout_ff;
endmodule : aftp_fifo
`default_nettype wire

// >>> verification/aftp_sink.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Receiver stand-in: takes frames and can stall.
module aftp_sink
    import aftp_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Frame link.
    input wire logic frm_valid,
    output logic frm_ready,
    input wire aftp_frame_s frm,
    // Stall request from the bench.
    input wire logic stall
);
    aftp_frame_s got[$];
    // Ready is the inverse of stall, which the bench moves just after an edge.
    assign frm_ready = !stall;
    // Frames are kept whole; the bench decodes with the same split.
    always @(posedge clk) begin
        if (frm_valid && frm_ready) begin
            got.push_back(frm);
        end
    end
endmodule : aftp_sink
`default_nettype wire

// >>> verification/aftp_packer_sva.sv
`timescale 1ns/1ns
`default_nettype none
module aftp_packer_sva
    import aftp_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Sample side.
    input wire logic smp_valid,
    input wire logic smp_ready,
    input wire aftp_sample_s smp,
    input wire logic ser_enable,
    // Frame side.
    input wire logic frm_valid,
    input wire logic frm_ready,
    input wire aftp_frame_s frm
);
    // ==========================================================
    // Frames owed; a frame with none owed would be invented.
    logic [5:0] owe_ff;
    logic [5:0] nxt_owe;
    always_comb begin
        nxt_owe = owe_ff + 6'(smp_valid && smp_ready)
            - 6'(frm_valid && frm_ready);
        if (srst) nxt_owe = '0;
    end
    // Register the count.
    always_ff @(posedge clk) owe_ff <= nxt_owe;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_take; smp_valid && smp_ready && owe_ff == 6'h00; endsequence
    sequence s_fill; !frm_valid [*2] ##1 frm_valid; endsequence
    AST_FILL: assert property (s_take |=> s_fill)
        else $error("frame late");
    AST_NOSPUR: assert property (frm_valid |-> owe_ff != 6'h00)
        else $error("frame without sample");
    AST_HOLD: assert property (frm_valid && !frm_ready |=>
        frm_valid && $stable(frm)) else $error("frame dropped");
    AST_UP: assert property ($fell(srst) |=> smp_ready)
        else $error("not ready after reset");
    AST_S16: assert property (frm_valid && frm.ser_fmt != AFTP_SER_NONE
        && frm.class_code inside {[12'h011:12'h014], [12'h01B:12'h01C]}
        |-> frm.split == AFTP_SPLIT_16_8) else $error("split not 16");
    AST_S14: assert property (frm_valid && frm.ser_fmt != AFTP_SER_NONE
        && frm.class_code inside {[12'h015:12'h01A]}
        |-> frm.split == AFTP_SPLIT_14_10) else $error("split not 14");
    AST_ENH: assert property (frm_valid && frm.ser_fmt == AFTP_SER_ENH
        |-> !frm.ser_err_valid) else $error("error byte in enhanced");
    AST_ERR: assert property (frm_valid && frm.ser_err_valid |->
        frm.ser_err_id == 4'hF && frm.ser_err_byte[7:6] == 2'b00
        && frm.ser_err_byte != 8'h00) else $error("bad error byte");
    sequence s_dual_bad; smp.dual_throttle && smp.ch1_fault; endsequence
    AST_DUALF: assert property ((s_take ##0 s_dual_bad) |=> ##2
        frm.nibbles[23:12] == 12'hFFF) else $error("dual fault not ones");
    AST_SEROFF: assert property ((s_take ##0 !ser_enable) |=> ##2
        frm.ser_fmt == AFTP_SER_NONE) else $error("serial while off");
endmodule : aftp_packer_sva
bind aftp_packer aftp_packer_sva i_sva (.clk(clk), .srst(srst),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp(smp),
    .ser_enable(ser_enable), .frm_valid(frm_valid),
    .frm_ready(frm_ready), .frm(frm));
`default_nettype wire

// >>> verification/aftp_packer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module aftp_packer_tb
    import aftp_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic smp_valid = 1'b0;
    logic ser_enable = 1'b0;
    logic stall = 1'b0;
    logic smp_ready;
    logic frm_valid;
    logic frm_ready;
    aftp_sample_s smp = '0;
    aftp_frame_s frm;
    aftp_sample_s q[$];
    int bad_count = 0;
    int compares = 0;
    // ==========================================================
    // Clock, design and receiver.
    always #20 clk = ~clk;
    aftp_packer i_dut (.clk(clk), .srst(srst), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .smp(smp), .ser_enable(ser_enable),
        .frm_valid(frm_valid), .frm_ready(frm_ready), .frm(frm));
    aftp_sink i_sink (.clk(clk), .frm_valid(frm_valid),
        .frm_ready(frm_ready), .frm(frm), .stall(stall));
    task automatic cmp(string what, logic [23:0] exp, logic [23:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask : cmp
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    function automatic aftp_sample_s mk(logic d, logic [11:0] c, logic l,
        logic f1, logic f2, logic [5:0] r);
        return '{d, c, l, 16'hA5C3, 12'h9B7, f1, f2, r};
    endfunction : mk
    // Offer the queue back to back, then check every frame in order.
    task automatic run_q();
        int w1;
        int n;
        logic [23:0] m2;
        logic [23:0] nib;
        aftp_frame_s f;
        foreach (q[i]) begin
            smp = q[i];
            smp_valid = 1'b1;
            while (!smp_ready) @(posedge clk) #1;
            @(posedge clk) #1;
        end
        smp_valid = 1'b0;
        foreach (q[i]) begin
            w1 = q[i].dual_throttle ? 12 : q[i].class_code inside
                {[12'h011:12'h014], [12'h01B:12'h01C]} ? 16 :
                q[i].class_code inside {[12'h015:12'h01A]} ? 14 : 12;
            m2 = (24'h1 << (24 - w1)) - 24'h1;
            nib = ({8'h00, q[i].ch1} << (24 - w1))
                | ({12'h000, q[i].ch2} & m2);
            if (q[i].ch1_fault) nib = (q[i].legacy && !q[i].dual_throttle) ?
                nib & m2 : nib | ~m2;
            if (q[i].ch2_fault) nib = (q[i].legacy || q[i].dual_throttle) ?
                nib & ~m2 : nib | m2;
            // An unused second channel sends zeros even when flagged faulty.
            if (!q[i].dual_throttle && q[i].class_code inside {12'h011,
                12'h012, 12'h017, 12'h018, 12'h01D}) nib = nib & ~m2;
            n = 0;
            while (i_sink.got.size() == 0 && n < 50) begin
                @(posedge clk) #1;
                n++;
            end
            cmp("frame_seen", 24'h1, 24'(i_sink.got.size() != 0));
            f = '0;
            if (i_sink.got.size() != 0) f = i_sink.got.pop_front();
            cmp("split", 24'(w1 == 16 ? AFTP_SPLIT_16_8 : w1 == 14 ?
                AFTP_SPLIT_14_10 : AFTP_SPLIT_12_12), 24'(f.split));
            cmp("class", 24'(q[i].class_code), 24'(f.class_code));
            cmp("nibbles", nib, f.nibbles);
            cmp("ser_fmt", (q[i].dual_throttle || !ser_enable) ? 0 :
                q[i].legacy ? 1 : 2, 24'(f.ser_fmt));
            cmp("err_valid", 24'(!q[i].dual_throttle && ser_enable &&
                q[i].legacy && |q[i].range_flags), 24'(f.ser_err_valid));
            if (f.ser_err_valid === 1'b1) cmp("err_byte", {4'hF,
                2'b00, q[i].range_flags}, {f.ser_err_id, f.ser_err_byte});
        end
        q.delete();
    endtask : run_q
    task automatic t_dual();
        ser_enable = 1'b1;
        for (int i = 3; i >= 0; i--) q.push_back(mk(1, 12'h010, 0, i[0],
            i[1], 0));
        run_q();
        $display("done dual throttle");
    endtask : t_dual
    task automatic t_classes();
        for (int i = 0; i < 16; i++) q.push_back(mk(0, 12'h010 + 12'(i), 0, 0, 0, 0));
        run_q();
        $display("done classes");
    endtask : t_classes
    task automatic t_faults();
        ser_enable = 1'b0;
        for (int i = 0; i < 12; i++) q.push_back(mk(0, i[3] ? 12'h017 :
            i[0] ? 12'h015 : 12'h013, i[1], i[2], !i[2], 0));
        run_q();
        $display("done faults");
    endtask : t_faults
    task automatic t_short();
        ser_enable = 1'b1;
        for (int i = 0; i < 8; i++) q.push_back(mk(0, 12'h01E, 1, 0, 0,
            i == 7 ? 6'h3F : 6'(i == 0 ? 0 : 1 << (i - 1))));
        run_q();
        $display("done short serial");
    endtask : t_short
    task automatic t_fill();
        int n;
        n = 0;
        stall = 1'b1;
        smp = mk(0, 12'h013, 0, 0, 0, 0);
        smp_valid = 1'b1;
        repeat (24) begin
            n += int'(smp_ready);
            @(posedge clk) #1;
        end
        smp_valid = 1'b0;
        cmp("refused", 0, 24'(smp_ready));
        cmp("held", 1, 24'(n >= 16));
        repeat (80) begin
            stall = !stall;
            @(posedge clk) #1;
        end
        stall = 1'b0;
        cmp("drained", 24'(n), 24'(i_sink.got.size()));
        $display("done fill");
    endtask : t_fill
    // Main sequence; the watchdog cuts a hang short.
    initial begin
        repeat (6) @(posedge clk);
        #1 srst = 1'b0;
        @(posedge clk) #1;
        t_dual();
        t_classes();
        t_faults();
        t_short();
        t_fill();
        report_and_stop();
    end
    initial begin
        #400000;
        bad_count++;
        report_and_stop();
    end
endmodule : aftp_packer_tb
`default_nettype wire
